// file: alternating_current_io_module_pkg.sv
// constants, register map and carrier types for the ac discrete channel
// assumes a 100 mhz pclk; every time is derived from CLK_HZ
package alternating_current_io_module_pkg;

  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_MS = 50;
  localparam int SAMPLE_MS = 20;
  localparam int SECOND_MS = 1000;
  localparam int TICK_CYCLES = TICK_MS * (CLK_HZ / 1000);
  localparam int SAMPLE_CYCLES = SAMPLE_MS * (CLK_HZ / 1000);
  localparam int SECOND_CYCLES = SECOND_MS * (CLK_HZ / 1000);

  //////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] SCAN_PERIOD_OFS = 8'h04;
  localparam logic [7:0] STATUS_OFS = 8'h08;
  localparam logic [7:0] ACCUM_OFS = 8'h0c;
  localparam logic [7:0] ON_CNT_OFS = 8'h10;
  localparam logic [7:0] OFF_CNT_OFS = 8'h14;
  localparam logic [7:0] ACTUAL_SCAN_OFS = 8'h18;
  localparam logic [7:0] DO_CTRL_OFS = 8'h1c;

  // status register bit positions
  localparam int ST_STATUS = 0;
  localparam int ST_PHYSICAL = 1;
  localparam int ST_ALARM = 2;
  localparam int ST_POINT_FAIL = 3;
  localparam int ST_MANUAL = 4;
  localparam int ST_DO_FAULT = 5;
  localparam int ST_DO_OUT = 6;
  // do control bit positions
  localparam int DO_CMD_BIT = 0;
  localparam int DO_RESET_BIT = 1;

  localparam logic [1:0] ACT_SHUTDOWN_LOG = 2'h0;
  localparam logic [1:0] ACT_LOG_ONLY = 2'h1;
  localparam logic [1:0] ACT_NONE = 2'h2;

  localparam logic [1:0] LOG_NONE = 2'h0;
  localparam logic [1:0] LOG_OUTPUT_FAULT = 2'h1;
  localparam logic [1:0] LOG_SCAN_OFF = 2'h2;

  typedef struct packed {
    logic [7:0] filter;
    logic [1:0] fail_action;
    logic rep_clear;
    logic rep_set;
    logic alarm_enable;
    logic latched;
    logic invert;
    logic scan_enable;
  } ctrl_t;

  localparam ctrl_t CTRL_RESET = 16'h0001;
  localparam logic [15:0] SCAN_PERIOD_RESET = 16'h0001;

  typedef struct packed {
    logic pulse;
    logic [1:0] code;
  } log_event_t;

  typedef enum logic {do_running, do_faulted} do_state_t;

endpackage

// file: ac_discrete_channel_conditioning.sv
// one ac discrete channel: input conditioning, counters, output alarms
// assumes an apb master on pclk and asynchronous field pins
//
// Operation
// - alarming disabled raises no limit alarm; enabled raises them normally.
// - point fail is shown as active but never goes to the log.
// - with alarming enabled, disabling scanning raises an alarm.
// - on-set option sends an exception report on alarm entry.
// - on-clear option sends an exception report on alarm exit.
// - output alarm applies action: shutdown and log, log only, or nothing.
// - each input can be sampled up to fifty times per second.
// - the input is scanned at the configured period in seconds.
// - raw hardware state is kept apart from processed status.
// - scanning disabled stops field processing; status holds.
// - standard mode status follows the conditioned input.
// - latched mode holds on after off-to-on until host clears status.
// - inversion complements the field input before the status.
// - on is recognised after high for filter count, zero to 255.
// - on-to-off is recognised at once, without filter delay.
// - 32-bit accumulator counts off-to-on transitions, saturating at all ones.
// - host may preset the accumulator; writing zero clears it.
// - 32-bit on counter counts 50 ms periods while on, wraps.
// - 32-bit off counter counts 50 ms periods while off, wraps.
// - host writes preset on and off counters; zero clears.
// - on and off counters stop while scanning is disabled.
// - real seconds between successive scans are measured and shown.
// - after fault shutdown the output stays off until a fault reset.
module ac_discrete_channel_conditioning #(
  parameter int TICK_CYC = alternating_current_io_module_pkg::TICK_CYCLES,
  parameter int SAMPLE_CYC = alternating_current_io_module_pkg::SAMPLE_CYCLES,
  parameter int SECOND_CYC = alternating_current_io_module_pkg::SECOND_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic field_in,
  input wire logic point_fail_in,
  input wire logic do_fault_in,
  output logic do_out,
  output logic exception_report,
  output alternating_current_io_module_pkg::log_event_t alarm_log
);

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    alternating_current_io_module_pkg::ctrl_t ctrl;
    logic [15:0] scan_period;
    logic [2:0] field_sync;
    logic [2:0] fail_sync;
    logic [2:0] dofault_sync;
    logic field_stable;
    logic fail_stable;
    logic dofault_stable;
    logic [31:0] tick_cnt;
    logic [31:0] sample_cnt;
    logic [31:0] sec_cnt;
    logic [7:0] filt_cnt;
    logic filtered;
    logic [15:0] secs_since_scan;
    logic [15:0] actual_scan;
    logic status;
    logic [31:0] accum;
    logic [31:0] on_cnt;
    logic [31:0] off_cnt;
    alternating_current_io_module_pkg::do_state_t do_state;
    logic do_cmd;
    logic do_out;
    logic alarm_prev;
    logic exc_rep;
    alternating_current_io_module_pkg::log_event_t log_ev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // free running divider; returns the next count, wrapping at lim
  function automatic logic [31:0] div_next(input logic [31:0] cnt,
                                           input int lim);
    if (cnt >= 32'(lim - 1)) begin
      return 32'h0;
    end
    return cnt + 32'h1;
  endfunction

  function automatic logic div_hit(input logic [31:0] cnt, input int lim);
    return cnt >= 32'(lim - 1);
  endfunction

  // a pin change counts once the second and third stages agree
  function automatic logic settle(input logic [2:0] sync, input logic cur);
    return (sync[1] == sync[2]) ? sync[2] : cur;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    case (a)
      alternating_current_io_module_pkg::CTRL_OFS, alternating_current_io_module_pkg::SCAN_PERIOD_OFS, alternating_current_io_module_pkg::STATUS_OFS,
      alternating_current_io_module_pkg::ACCUM_OFS, alternating_current_io_module_pkg::ON_CNT_OFS, alternating_current_io_module_pkg::OFF_CNT_OFS,
      alternating_current_io_module_pkg::ACTUAL_SCAN_OFS, alternating_current_io_module_pkg::DO_CTRL_OFS: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  logic wr;
  logic setup;
  logic tick;
  logic sample_tick;
  logic sec_tick;
  logic scan_now;
  logic cond_in;
  logic status_new;
  logic alarm_now;
  logic fault_alarm;
  logic [31:0] status_word;

  always_comb begin
    state_next = state_reg;
    setup = psel && !penable;
    wr = psel && penable && pwrite && state_reg.pready;

    // pins: three flip-flops, first stage read only by the second
    state_next.field_sync = {state_reg.field_sync[1:0], field_in};
    state_next.fail_sync = {state_reg.fail_sync[1:0], point_fail_in};
    state_next.dofault_sync = {state_reg.dofault_sync[1:0], do_fault_in};
    state_next.field_stable = settle(state_reg.field_sync,
                                     state_reg.field_stable);
    state_next.fail_stable = settle(state_reg.fail_sync,
                                    state_reg.fail_stable);
    state_next.dofault_stable = settle(state_reg.dofault_sync,
                                       state_reg.dofault_stable);

    // time bases
    tick = div_hit(state_reg.tick_cnt, TICK_CYC);
    sample_tick = div_hit(state_reg.sample_cnt, SAMPLE_CYC);
    sec_tick = div_hit(state_reg.sec_cnt, SECOND_CYC);
    state_next.tick_cnt = div_next(state_reg.tick_cnt, TICK_CYC);
    state_next.sample_cnt = div_next(state_reg.sample_cnt, SAMPLE_CYC);
    state_next.sec_cnt = div_next(state_reg.sec_cnt, SECOND_CYC);

    // on filter on raw level; a drop clears at once and restarts the count
    if (!state_reg.field_stable) begin
      state_next.filt_cnt = 8'h0;
      state_next.filtered = 1'b0;
    end else if (state_reg.filt_cnt >= state_reg.ctrl.filter) begin
      state_next.filtered = 1'b1;
    end else if (tick) begin
      state_next.filt_cnt = state_reg.filt_cnt + 8'h1;
    end

    // scan scheduling; a zero period scans at the fastest sample rate
    if (sec_tick) begin
      state_next.secs_since_scan = state_reg.secs_since_scan + 16'h1;
    end
    if (state_reg.scan_period == 16'h0) begin
      scan_now = sample_tick;
    end else begin
      scan_now = sec_tick &&
        (state_reg.secs_since_scan + 16'h1 >= state_reg.scan_period);
    end
    scan_now = scan_now && state_reg.ctrl.scan_enable;
    if (scan_now) begin
      state_next.actual_scan = sec_tick ?
        state_reg.secs_since_scan + 16'h1 : state_reg.secs_since_scan;
      state_next.secs_since_scan = 16'h0;
    end

    // conditioning: invert, then standard or latched
    cond_in = state_reg.filtered ^ state_reg.ctrl.invert;
    if (state_reg.ctrl.latched) begin
      status_new = state_reg.status | cond_in;
    end else begin
      status_new = cond_in;
    end
    if (scan_now) begin
      state_next.status = status_new;
    end

    // transition accumulator, saturating
    if (state_next.status && !state_reg.status &&
        state_reg.accum != 32'hffff_ffff) begin
      state_next.accum = state_reg.accum + 32'h1;
    end

    // time in state, frozen while not scanning
    if (tick && state_reg.ctrl.scan_enable) begin
      if (state_reg.status) begin
        state_next.on_cnt = state_reg.on_cnt + 32'h1;
      end else begin
        state_next.off_cnt = state_reg.off_cnt + 32'h1;
      end
    end

    // output alarm and exception reporting
    fault_alarm = state_reg.ctrl.alarm_enable && state_reg.dofault_stable;
    alarm_now = state_reg.ctrl.alarm_enable &&
      (state_reg.dofault_stable || !state_reg.ctrl.scan_enable);
    state_next.alarm_prev = alarm_now;
    state_next.exc_rep =
      (state_reg.ctrl.rep_set && alarm_now &&
       !state_reg.alarm_prev) ||
      (state_reg.ctrl.rep_clear && !alarm_now &&
       state_reg.alarm_prev);
    state_next.log_ev.pulse = 1'b0;
    state_next.log_ev.code = alternating_current_io_module_pkg::LOG_NONE;
    // point fail never feeds the log path
    if (alarm_now && !state_reg.alarm_prev) begin
      if (fault_alarm) begin
        if (state_reg.ctrl.fail_action == alternating_current_io_module_pkg::ACT_SHUTDOWN_LOG ||
            state_reg.ctrl.fail_action == alternating_current_io_module_pkg::ACT_LOG_ONLY) begin
          state_next.log_ev.pulse = 1'b1;
          state_next.log_ev.code = alternating_current_io_module_pkg::LOG_OUTPUT_FAULT;
        end
      end else begin
        state_next.log_ev.pulse = 1'b1;
        state_next.log_ev.code = alternating_current_io_module_pkg::LOG_SCAN_OFF;
      end
    end

    // fault state; a new fault beats a reset in the same cycle
    case (state_reg.do_state)
      alternating_current_io_module_pkg::do_running: begin
        if (fault_alarm &&
            state_reg.ctrl.fail_action == alternating_current_io_module_pkg::ACT_SHUTDOWN_LOG) begin
          state_next.do_state = alternating_current_io_module_pkg::do_faulted;
        end
      end
      alternating_current_io_module_pkg::do_faulted: begin
        if (wr && paddr == alternating_current_io_module_pkg::DO_CTRL_OFS &&
            pwdata[alternating_current_io_module_pkg::DO_RESET_BIT] && !fault_alarm) begin
          state_next.do_state = alternating_current_io_module_pkg::do_running;
        end
      end
      default: state_next.do_state = alternating_current_io_module_pkg::do_faulted;
    endcase

    // register writes take priority over hardware updates, except a latching scan on status
    if (wr) begin
      case (paddr)
        alternating_current_io_module_pkg::CTRL_OFS: state_next.ctrl = pwdata[15:0];
        alternating_current_io_module_pkg::SCAN_PERIOD_OFS: state_next.scan_period = pwdata[15:0];
        // a latching scan in the same cycle beats the host clear
        alternating_current_io_module_pkg::STATUS_OFS:
          state_next.status = pwdata[alternating_current_io_module_pkg::ST_STATUS] ||
            (state_reg.ctrl.latched && scan_now && cond_in);
        alternating_current_io_module_pkg::ACCUM_OFS: state_next.accum = pwdata;
        alternating_current_io_module_pkg::ON_CNT_OFS: state_next.on_cnt = pwdata;
        alternating_current_io_module_pkg::OFF_CNT_OFS: state_next.off_cnt = pwdata;
        alternating_current_io_module_pkg::DO_CTRL_OFS:
          state_next.do_cmd = pwdata[alternating_current_io_module_pkg::DO_CMD_BIT];
        default: state_next.do_cmd = state_reg.do_cmd;
      endcase
    end
    // shutdown forces the output off regardless of command
    state_next.do_out = state_next.do_cmd &&
      (state_next.do_state == alternating_current_io_module_pkg::do_running);

    status_word = 32'h0;
    status_word[alternating_current_io_module_pkg::ST_STATUS] = state_reg.status;
    status_word[alternating_current_io_module_pkg::ST_PHYSICAL] = state_reg.field_stable;
    status_word[alternating_current_io_module_pkg::ST_ALARM] = alarm_now;
    status_word[alternating_current_io_module_pkg::ST_POINT_FAIL] = state_reg.fail_stable;
    status_word[alternating_current_io_module_pkg::ST_MANUAL] = !state_reg.ctrl.scan_enable;
    status_word[alternating_current_io_module_pkg::ST_DO_FAULT] =
      (state_reg.do_state == alternating_current_io_module_pkg::do_faulted);
    status_word[alternating_current_io_module_pkg::ST_DO_OUT] = state_reg.do_out;

    // apb: answer is prepared in setup, so access always ends in one cycle
    state_next.pready = setup;
    state_next.pslverr = setup && !mapped(paddr);
    state_next.prdata = 32'h0;
    if (setup && !pwrite) begin
      case (paddr)
        alternating_current_io_module_pkg::CTRL_OFS: state_next.prdata = {16'h0, state_reg.ctrl};
        alternating_current_io_module_pkg::SCAN_PERIOD_OFS:
          state_next.prdata = {16'h0, state_reg.scan_period};
        alternating_current_io_module_pkg::STATUS_OFS: state_next.prdata = status_word;
        alternating_current_io_module_pkg::ACCUM_OFS: state_next.prdata = state_reg.accum;
        alternating_current_io_module_pkg::ON_CNT_OFS: state_next.prdata = state_reg.on_cnt;
        alternating_current_io_module_pkg::OFF_CNT_OFS: state_next.prdata = state_reg.off_cnt;
        alternating_current_io_module_pkg::ACTUAL_SCAN_OFS:
          state_next.prdata = {16'h0, state_reg.actual_scan};
        alternating_current_io_module_pkg::DO_CTRL_OFS: state_next.prdata = {31'h0, state_reg.do_cmd};
        default: state_next.prdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= '0;
      state_reg.ctrl <= alternating_current_io_module_pkg::CTRL_RESET;
      state_reg.scan_period <= alternating_current_io_module_pkg::SCAN_PERIOD_RESET;
      state_reg.do_state <= alternating_current_io_module_pkg::do_running;
    end else begin
      state_reg <= state_next;
    end
  end

  assign prdata = state_reg.prdata;
  assign pready = state_reg.pready;
  assign pslverr = state_reg.pslverr;
  assign do_out = state_reg.do_out;
  assign exception_report = state_reg.exc_rep;
  assign alarm_log = state_reg.log_ev;

endmodule

// file: alternating_current_io_module_checker.sv
// port-level checks of the ac discrete channel
// assumes one pclk domain and an apb master with no wait states
module alternating_current_io_module_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic exception_report,
  input wire alternating_current_io_module_pkg::log_event_t alarm_log
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence setup_s;
    psel && !penable;
  endsequence
  // unaligned or past the last register
  sequence bad_s;
    setup_s ##0 (paddr > 8'h1c || paddr[1:0] != 2'h0);
  endsequence
  sequence good_s;
    setup_s ##0 (paddr <= 8'h1c && paddr[1:0] == 2'h0);
  endsequence
  ////////////////////////////////////////////////////////////////////////
  a_ready_access: assert property (setup_s |=> pready && penable)
    else $error("no ready in access cycle");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_cause: assert property (pready |-> $past(psel && !penable))
    else $error("ready without setup");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error outside access");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access");
  a_unmapped_err: assert property (bad_s |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (good_s |=> !pslverr)
    else $error("mapped access refused");
  a_report_pulse: assert property (exception_report |=> !exception_report)
    else $error("report longer than a cycle");
  a_log_pulse: assert property (alarm_log.pulse |=> !alarm_log.pulse)
    else $error("log longer than a cycle");
  a_log_code: assert property (alarm_log.code != 2'h3 &&
    alarm_log.pulse == (alarm_log.code != 2'h0))
    else $error("bad log code");
  c_log: cover property (alarm_log.pulse);
endmodule

bind ac_discrete_channel_conditioning alternating_current_io_module_checker i_alternating_current_io_module_checker (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .exception_report(exception_report),
  .alarm_log(alarm_log));

// file: ac_field_model.sv
// field side: ac sense, hardware fail and output fault detectors
// assumes the bench commands levels just after a rising pclk edge
module ac_field_model (
  input wire logic pclk,
  input wire logic ac_on,
  input wire logic fail,
  input wire logic fault,
  output logic field_in,
  output logic point_fail_in,
  output logic do_fault_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // one flop of sensing lag, as a real detector never answers at once
  always @(posedge pclk) begin
    field_in <= ac_on;
    point_fail_in <= fail;
    do_fault_in <= fault;
  end
endmodule

// file: tb_ac_discrete_channel_conditioning.sv
// self-checking bench for the ac discrete channel over apb
// assumes the package, the checker and the field model compile first
module tb_ac_discrete_channel_conditioning;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CTL = alternating_current_io_module_pkg::CTRL_OFS;
  localparam logic [7:0] ST = alternating_current_io_module_pkg::STATUS_OFS;
  localparam logic [7:0] ACC = alternating_current_io_module_pkg::ACCUM_OFS;
  localparam logic [7:0] DOC = alternating_current_io_module_pkg::DO_CTRL_OFS;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ac_on = 1'b0, fail = 1'b0, fault = 1'b0;
  logic [31:0] pwdata = 32'h0, prdata, q, q0, r0;
  logic pready, pslverr, err, field_in, point_fail_in, do_fault_in;
  logic do_out, exception_report;
  alternating_current_io_module_pkg::log_event_t alarm_log;
  int n_fail = 0, cmp_count = 0, n_rep = 0, n_log = 0;
  logic [3:0] seen = 4'h0;
  always #5 pclk = ~pclk;
  ac_discrete_channel_conditioning #(.TICK_CYC(50), .SAMPLE_CYC(20),
    .SECOND_CYC(1000)) i_ac_discrete_channel_conditioning (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .field_in(field_in), .point_fail_in(point_fail_in),
    .do_fault_in(do_fault_in), .do_out(do_out),
    .exception_report(exception_report), .alarm_log(alarm_log));
  ac_field_model i_ac_field_model (.pclk(pclk), .ac_on(ac_on),
    .fail(fail), .fault(fault), .field_in(field_in),
    .point_fail_in(point_fail_in), .do_fault_in(do_fault_in));
  always @(posedge pclk) begin
    if (alarm_log.pulse === 1'b1) seen[alarm_log.code] <= 1'b1;
    if (alarm_log.pulse === 1'b1) n_log <= n_log + 1;
    if (exception_report === 1'b1) n_rep <= n_rep + 1;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // idle edge first, so back-to-back calls never drive psel twice
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      n_fail++;
      stop_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic poll(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      xfer(1'b0, a, 32'h0);
      if ((q & m) === v) break;
    end
    chk(q & m, v);
  endtask
  // setup edges exactly 200 cycles apart span four 50-cycle ticks
  task automatic span(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    q0 = q;
    repeat (197) @(posedge pclk);
    xfer(1'b0, a, 32'h0);
    chk(q - q0, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(CTL, 32'h1);
    rd(alternating_current_io_module_pkg::SCAN_PERIOD_OFS, 32'h1);
    rd(8'h20, 32'h0);
    chk(err, 32'h1);
    wr(alternating_current_io_module_pkg::SCAN_PERIOD_OFS, 32'h0);
    wr(CTL, 32'h0201);
    ac_on <= 1'b1;
    repeat (40) @(posedge pclk);
    rd(ST, 32'h2);
    poll(ST, 32'h1, 32'h1, 40);
    rd(ACC, 32'h1);
    ac_on <= 1'b0;
    poll(ST, 32'h3, 32'h0, 20);
    span(alternating_current_io_module_pkg::OFF_CNT_OFS, 32'h4);
    wr(CTL, 32'h0203);
    poll(ST, 32'h1, 32'h1, 10);
    wr(alternating_current_io_module_pkg::ON_CNT_OFS, 32'hffff_ffff);
    span(alternating_current_io_module_pkg::ON_CNT_OFS, 32'h4);
    wr(CTL, 32'h0205);
    wr(ST, 32'h0);
    wr(ACC, 32'hffff_ffff);
    ac_on <= 1'b1;
    poll(ST, 32'h1, 32'h1, 40);
    rd(ACC, 32'hffff_ffff);
    ac_on <= 1'b0;
    repeat (60) @(posedge pclk);
    rd(ST, 32'h1);
    wr(ST, 32'h0);
    rd(ST, 32'h0);
    wr(ACC, 32'h0);
    rd(ACC, 32'h0);
    wr(CTL, 32'h0001);
    wr(DOC, 32'h1);
    fault <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(do_out, 32'h1);
    chk(n_log, 32'h0);
    fault <= 1'b0;
    // shutdown, log only, no action; reports on set and on clear
    for (int a = 0; a < 3; a++) begin
      repeat (10) @(posedge pclk);
      q0 = n_log;
      r0 = n_rep;
      wr(DOC, 32'h3);
      wr(CTL, 32'h0039 | (a << 6));
      fault <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(do_out, a != 0);
      chk(n_log - q0, a != 2);
      fault <= 1'b0;
      repeat (10) @(posedge pclk);
      chk(do_out, a != 0);
      chk(n_rep - r0, 32'h2);
      wr(CTL, 32'h0001);
    end
    wr(DOC, 32'h3);
    repeat (3) @(posedge pclk);
    chk(do_out, 32'h1);
    chk(seen[1], 32'h1);
    wr(CTL, 32'h0009);
    wr(CTL, 32'h0008);
    ac_on <= 1'b1;
    span(alternating_current_io_module_pkg::OFF_CNT_OFS, 32'h0);
    chk(seen[2], 32'h1);
    q0 = n_log;
    fail <= 1'b1;
    poll(ST, 32'h8, 32'h8, 10);
    chk(n_log - q0, 32'h0);
    fail <= 1'b0;
    xfer(1'b0, ST, 32'h0);
    chk(q & 32'h3, 32'h2);
    wr(CTL, 32'h0001);
    wr(alternating_current_io_module_pkg::SCAN_PERIOD_OFS, 32'h1);
    repeat (2100) @(posedge pclk);
    rd(alternating_current_io_module_pkg::ACTUAL_SCAN_OFS, 32'h1);
    stop_test();
  end
endmodule
